// ### design/mrd_burst_if.sv
//==========================================================================
// Burst ordering request and answer
interface mrd_burst_if;
  logic [1:0] start; // Starting lower column bits
  logic [1:0] beat; // Beat index
  logic len4; // Four-word burst
  logic ileave; // Interleave ordering
  logic [1:0] col; // Ordered lower column bits
  modport gen (input start, input beat, input len4, input ileave, output col);
  modport user (output start, output beat, output len4, output ileave, input col);
endinterface : mrd_burst_if

// ### design/mrd_burst_order.sv
//==========================================================================
// Lower column address of one beat
module mrd_burst_order (
  // Ordering request
  mrd_burst_if.gen bif
);
  logic [1:0] mask; // Bits inside the burst range
  logic [1:0] off; // Ordered value before masking

  // Only burst-range bits move; higher bits never see a carry
  always_comb begin
    mask = bif.len4 ? 2'h3 : 2'h1;
    if (bif.ileave) begin
      off = bif.start ^ bif.beat;
    end else begin
      off = bif.start + bif.beat;
    end
    bif.col = (bif.start & ~mask) | (off & mask);
  end
endmodule : mrd_burst_order

// ### design/mrd_pkg.sv
//==========================================================================
//==========================================================================
package mrd_pkg;

  //==========================================================================
  // Command codes on the decoded command pins
  localparam logic [2:0] CMD_NOP = 3'h0;
  localparam logic [2:0] CMD_READ_START = 3'h1;
  localparam logic [2:0] CMD_WRITE_START = 3'h2;
  localparam logic [2:0] CMD_LOWER_ADDR_LATCH = 3'h3;
  localparam logic [2:0] CMD_REG_SET = 3'h4;

  //==========================================================================
  // Mode register field layout and codes
  localparam int MR_LEN_LSB = 0;
  localparam int MR_TYPE_BIT = 3;
  localparam int MR_CL_LSB = 4;
  localparam int MR_TEST_BIT = 7;
  localparam int ER_DLL_BIT = 0;
  localparam int ER_DRV_LO_BIT = 1;
  localparam int ER_DRV_HI_BIT = 6;
  localparam logic [2:0] LEN_2 = 3'h1;
  localparam logic [2:0] LEN_4 = 3'h2;
  localparam logic [2:0] CL_4 = 3'h4;
  localparam logic [13:0] MR_RSV_MASK = 14'h3f00;
  localparam logic [13:0] ER_RSV_MASK = 14'h3fbc;
  localparam logic [1:0] BANK_REGULAR = 2'h0;
  localparam logic [1:0] BANK_EXTENDED = 2'h1;

  //==========================================================================
  // Latency countdown: load value and firing points (burst starts a cycle later)
  localparam logic [2:0] LAT_LOAD = 3'h3;
  localparam logic [2:0] RD_FIRE_CNT = 3'h2;
  localparam logic [2:0] WR_FIRE_CNT = 3'h3;
  localparam logic [1:0] LAST_BEAT_2 = 2'h1;
  localparam logic [1:0] LAST_BEAT_4 = 2'h3;

  //==========================================================================
  // Wishbone register offsets and fields
  localparam logic [3:0] OFS_REGULAR = 4'h0;
  localparam logic [3:0] OFS_EXTENDED = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h8;
  localparam logic [3:0] OFS_CTRL = 4'hc;
  localparam int ST_BANK_ERR = 2;
  localparam int ST_FIELD_ERR = 3;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam logic DLL_EN_RST = 1'b1;

  //==========================================================================
  // Command sequencer states
  typedef enum logic [1:0] {
    MRD_IDLE = 2'b00,
    MRD_RD_PEND = 2'b01,
    MRD_WR_PEND = 2'b10
  } mrd_state_type;

  // All state of the top module
  typedef struct packed {
    logic [2:0] cmd1;
    logic [2:0] cmd2;
    logic [13:0] adr1;
    logic [13:0] adr2;
    logic [2:0] bnk1;
    logic [2:0] bnk2;
    mrd_state_type st;
    logic [2:0] lat;
    logic pend;
    logic pend_wr;
    logic busy;
    logic busy_wr;
    logic [13:0] base;
    logic [1:0] beat;
    logic [2:0] mr_len;
    logic mr_ilv;
    logic [2:0] mr_cl;
    logic mr_test;
    logic dll_en;
    logic [1:0] er_drv;
    logic reg_set;
    logic ext_set;
    logic bank_err;
    logic field_err;
    logic cmd_en;
    logic ack;
    logic [31:0] dat;
    logic beat_vld;
    logic beat_wr;
    logic [13:0] col;
  } mrd_top_state_type;

endpackage : mrd_pkg

// ### design/mrd_top.sv
//==========================================================================
// Mode register decode and burst address ordering
//
// Our own choices: the placing of the registers and the Wishbone interface to the registers.
module mrd_top
  import mrd_pkg::*;
#(
  parameter int ADDR_W = 14
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Command pins
  input wire logic [2:0] cmd_i,
  input wire logic [13:0] addr_i,
  input wire logic [2:0] bank_i,
  // Burst beats
  output logic beat_vld_o,
  output logic beat_wr_o,
  output logic [13:0] beat_col_o,
  // Extended mode settings
  output logic dll_en_o,
  output logic [1:0] drv_strength_o,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o
);

  // Address width is fixed by the pin map
  if (ADDR_W != 14) begin : g_bad_width
    $error("mrd_top: ADDR_W must be 14");
  end

  mrd_top_state_type s_ff; // Registered state
  mrd_top_state_type nxt_s; // Next state
  logic [2:0] cmd; // Command after enable gate
  logic hit; // New bus request
  mrd_burst_if bif (); // Link to ordering logic

  //==========================================================================
  // Burst ordering
  assign bif.start = s_ff.base[1:0];
  assign bif.beat = s_ff.beat;
  assign bif.len4 = (s_ff.mr_len == LEN_4);
  assign bif.ileave = s_ff.mr_ilv;

  mrd_burst_order u_order (
    .bif (bif.gen)
  );

  //==========================================================================
  // Next state
  always_comb begin
    nxt_s = s_ff;
    // Two-stage pin synchronisers
    nxt_s.cmd1 = cmd_i;
    nxt_s.adr1 = addr_i;
    nxt_s.bnk1 = bank_i;
    nxt_s.cmd2 = s_ff.cmd1;
    nxt_s.adr2 = s_ff.adr1;
    nxt_s.bnk2 = s_ff.bnk1;
    cmd = s_ff.cmd_en ? s_ff.cmd2 : CMD_NOP;
    hit = wb_cyc_i && wb_stb_i && !s_ff.ack;
    nxt_s.ack = hit;
    nxt_s.beat_vld = 1'b0;

    // Bus writes; clears come first so hardware sets below win
    if (hit && wb_we_i && wb_sel_i[0]) begin
      if (wb_adr_i == OFS_CTRL) begin
        nxt_s.cmd_en = wb_dat_i[0];
      end else if (wb_adr_i == OFS_STATUS) begin
        nxt_s.bank_err = s_ff.bank_err & ~wb_dat_i[ST_BANK_ERR];
        nxt_s.field_err = s_ff.field_err & ~wb_dat_i[ST_FIELD_ERR];
      end
    end

    // Bus read data from current state
    case (wb_adr_i)
      OFS_REGULAR: begin
        nxt_s.dat = {24'h0, s_ff.mr_test, s_ff.mr_cl, s_ff.mr_ilv, s_ff.mr_len};
      end
      OFS_EXTENDED: begin
        nxt_s.dat = {25'h0, s_ff.er_drv[1], 4'h0, s_ff.er_drv[0], ~s_ff.dll_en};
      end
      OFS_STATUS: begin
        nxt_s.dat = {27'h0, s_ff.busy, s_ff.field_err, s_ff.bank_err,
                     s_ff.ext_set, s_ff.reg_set};
      end
      OFS_CTRL: begin
        nxt_s.dat = {31'h0, s_ff.cmd_en};
      end
      default: begin
        nxt_s.dat = 32'h0;
      end
    endcase

    // Latency countdown toward the first beat
    if (s_ff.pend) begin
      nxt_s.lat = s_ff.lat - 3'h1;
      if (s_ff.lat == (s_ff.pend_wr ? WR_FIRE_CNT : RD_FIRE_CNT)) begin
        nxt_s.pend = 1'b0;
        nxt_s.busy = 1'b1;
        nxt_s.busy_wr = s_ff.pend_wr;
        nxt_s.beat = 2'h0;
      end
    end

    // Burst beats
    if (s_ff.busy) begin
      nxt_s.beat_vld = 1'b1;
      nxt_s.beat_wr = s_ff.busy_wr;
      nxt_s.col = {s_ff.base[13:2], bif.col};
      nxt_s.beat = s_ff.beat + 2'h1;
      if (s_ff.beat == (bif.len4 ? LAST_BEAT_4 : LAST_BEAT_2)) begin
        nxt_s.busy = 1'b0;
      end
    end

    // Two-command sequencer
    case (s_ff.st)
      MRD_IDLE: begin
        if (cmd == CMD_READ_START) begin
          nxt_s.st = MRD_RD_PEND;
        end else if (cmd == CMD_WRITE_START) begin
          nxt_s.st = MRD_WR_PEND;
        end
      end
      MRD_RD_PEND: begin
        nxt_s.st = MRD_IDLE;
        if (cmd == CMD_LOWER_ADDR_LATCH) begin
          // Only latency 4 exists, so the countdown load is fixed
          nxt_s.pend = 1'b1;
          nxt_s.pend_wr = 1'b0;
          nxt_s.lat = LAT_LOAD;
          nxt_s.base = s_ff.adr2;
        end else if (cmd == CMD_REG_SET) begin
          // Register set cancels the read
          if (s_ff.bnk2[1]) begin
            nxt_s.bank_err = 1'b1;
          end else if (s_ff.bnk2[1:0] == BANK_REGULAR) begin
            nxt_s.reg_set = 1'b1;
            nxt_s.mr_len = s_ff.adr2[MR_LEN_LSB +: 3];
            nxt_s.mr_ilv = s_ff.adr2[MR_TYPE_BIT];
            nxt_s.mr_cl = s_ff.adr2[MR_CL_LSB +: 3];
            nxt_s.mr_test = s_ff.adr2[MR_TEST_BIT];
            if (s_ff.adr2[MR_CL_LSB +: 3] != CL_4 || s_ff.adr2[MR_TEST_BIT]
                || (s_ff.adr2 & MR_RSV_MASK) != 14'h0 || s_ff.bnk2[2]
                || (s_ff.adr2[MR_LEN_LSB +: 3] != LEN_2
                    && s_ff.adr2[MR_LEN_LSB +: 3] != LEN_4)) begin
              nxt_s.field_err = 1'b1;
            end
          end else begin
            nxt_s.ext_set = 1'b1;
            nxt_s.dll_en = ~s_ff.adr2[ER_DLL_BIT];
            nxt_s.er_drv = {s_ff.adr2[ER_DRV_HI_BIT], s_ff.adr2[ER_DRV_LO_BIT]};
            if (s_ff.adr2[ER_DLL_BIT] || (s_ff.adr2 & ER_RSV_MASK) != 14'h0
                || s_ff.bnk2[2]) begin
              nxt_s.field_err = 1'b1;
            end
          end
        end
      end
      MRD_WR_PEND: begin
        nxt_s.st = MRD_IDLE;
        if (cmd == CMD_LOWER_ADDR_LATCH) begin
          nxt_s.pend = 1'b1;
          nxt_s.pend_wr = 1'b1;
          nxt_s.lat = LAT_LOAD;
          nxt_s.base = s_ff.adr2;
        end
      end
      default: begin
        nxt_s.st = MRD_IDLE;
      end
    endcase
  end

  //==========================================================================
  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_ff <= '0;
      s_ff.cmd_en <= CTRL_EN_RST;
      s_ff.dll_en <= DLL_EN_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  //==========================================================================
  // Outputs
  assign beat_vld_o = s_ff.beat_vld;
  assign beat_wr_o = s_ff.beat_wr;
  assign beat_col_o = s_ff.col;
  assign dll_en_o = s_ff.dll_en;
  assign drv_strength_o = s_ff.er_drv;
  assign wb_ack_o = s_ff.ack;
  assign wb_dat_o = s_ff.dat;

  //==========================================================================
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_latch_rd;
    s_ff.st == MRD_RD_PEND && s_ff.cmd_en && s_ff.cmd2 == CMD_LOWER_ADDR_LATCH && !s_ff.busy;
  endsequence
  sequence s_latch_wr;
    s_ff.st == MRD_WR_PEND && s_ff.cmd_en && s_ff.cmd2 == CMD_LOWER_ADDR_LATCH && !s_ff.busy;
  endsequence
  sequence s_rset;
    s_ff.st == MRD_RD_PEND && s_ff.cmd_en && s_ff.cmd2 == CMD_REG_SET;
  endsequence

  property p_rd_lat;
    // Three quiet cycles after the latch, first beat on the fourth
    s_latch_rd |=> !s_ff.beat_vld[*3] ##1 (s_ff.beat_vld && !s_ff.beat_wr);
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read latency wrong");

  property p_wr_lat;
    s_latch_wr |-> ##3 (s_ff.beat_vld && s_ff.beat_wr);
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write latch slot wrong");

  property p_seq4;
    s_ff.beat_vld && $past(s_ff.beat_vld) && !s_ff.mr_ilv && s_ff.mr_len == LEN_4
      |-> s_ff.col[1:0] == $past(s_ff.col[1:0]) + 2'h1
          && s_ff.col[13:2] == $past(s_ff.col[13:2]);
  endproperty
  a_seq4: assert property (p_seq4) else $error("sequential order wrong");

  property p_ilv4;
    s_latch_rd and (s_ff.mr_ilv && s_ff.mr_len == LEN_4)
      |-> ##4 s_ff.col[1:0] == $past(s_ff.adr2[1:0], 4)
          ##1 s_ff.col[1:0] == ($past(s_ff.adr2[1:0], 5) ^ 2'h1)
          ##1 s_ff.col[1:0] == ($past(s_ff.adr2[1:0], 6) ^ 2'h2)
          ##1 s_ff.col[1:0] == ($past(s_ff.adr2[1:0], 7) ^ 2'h3);
  endproperty
  a_ilv4: assert property (p_ilv4) else $error("interleave order wrong");

  property p_cl_rsv;
    s_rset and (s_ff.bnk2[1:0] == BANK_REGULAR && s_ff.adr2[MR_CL_LSB +: 3] != CL_4)
      |=> s_ff.field_err;
  endproperty
  a_cl_rsv: assert property (p_cl_rsv) else $error("bad latency not flagged");

  property p_dll;
    s_rset and (s_ff.bnk2 == {1'b0, BANK_EXTENDED})
      |=> dll_en_o == !$past(s_ff.adr2[ER_DLL_BIT]);
  endproperty
  a_dll: assert property (p_dll) else $error("loop switch wrong");

  property p_drv;
    s_rset and (s_ff.bnk2[1:0] == BANK_EXTENDED)
      |=> drv_strength_o == {$past(s_ff.adr2[ER_DRV_HI_BIT]), $past(s_ff.adr2[ER_DRV_LO_BIT])};
  endproperty
  a_drv: assert property (p_drv) else $error("driver strength wrong");

  property p_bank_rsv;
    s_rset and s_ff.bnk2[1]
      |=> s_ff.bank_err && $stable(s_ff.mr_len) && $stable(s_ff.er_drv) && $stable(s_ff.mr_cl);
  endproperty
  a_bank_rsv: assert property (p_bank_rsv) else $error("reserved bank wrote");

  property p_rset_gate;
    ($changed(s_ff.mr_len) || $changed(s_ff.er_drv))
      |-> $past(s_ff.st) == MRD_RD_PEND && s_ff.st == MRD_IDLE;
  endproperty
  a_rset_gate: assert property (p_rset_gate) else $error("register set out of turn");

  property p_len_field;
    s_rset and (s_ff.bnk2 == 3'h0) |=> s_ff.mr_len == $past(s_ff.adr2[MR_LEN_LSB +: 3])
      && s_ff.mr_ilv == $past(s_ff.adr2[MR_TYPE_BIT]);
  endproperty
  a_len_field: assert property (p_len_field) else $error("length or type not stored");

endmodule : mrd_top

// ### verification/mrd_ctrl_model.sv
//==========================================================================
// Memory controller model driving the command pins
module mrd_ctrl_model
  import mrd_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Command pins toward the device
  output logic [2:0] cmd_o,
  output logic [13:0] addr_o,
  output logic [2:0] bank_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // Pins idle at start
  initial begin
    cmd_o = CMD_NOP;
    addr_o = 14'h0000;
    bank_o = 3'h0;
  end

  // Two commands on consecutive edges; pins then show a changed pattern
  task automatic pair(input logic [2:0] c1, input logic [2:0] c2, input logic [13:0] a,
      input logic [2:0] b);
    @(posedge clk_i);
    cmd_o <= c1;
    addr_o <= a;
    bank_o <= b;
    @(posedge clk_i);
    cmd_o <= c2; // Second command on the very next clock
    @(posedge clk_i);
    cmd_o <= CMD_NOP;
    addr_o <= ~a;
    bank_o <= ~b;
  endtask : pair

  // Register set: read start then register set; banks 0 and 1 get reserved bits made legal, length bits left as given
  task automatic reg_set(input logic [2:0] b, input logic [13:0] a);
    logic [13:0] v;
    v = a;
    if (b[1:0] == BANK_REGULAR) begin
      v = v & ~MR_RSV_MASK;
      v[MR_TEST_BIT] = 1'b0;
      v[6:4] = CL_4;
    end else if (b[1:0] == BANK_EXTENDED) begin
      v = v & ~ER_RSV_MASK;
      v[ER_DLL_BIT] = 1'b0;
    end
    pair(CMD_READ_START, CMD_REG_SET, v, {1'b0, b[1:0]});
  endtask : reg_set
endmodule : mrd_ctrl_model

// ### verification/mrd_top_tb.sv
//==========================================================================
// Self-checking bench for mode decode and burst ordering
module mrd_top_tb;
  import mrd_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk_i, rst_i, wb_cyc, wb_stb, wb_we; // Clock, reset, bus strobes
  logic [3:0] wb_adr; // Bus offset
  logic [31:0] wb_dat; // Bus write data
  logic [2:0] cmd, bank; // Command and bank pins
  logic [13:0] addr; // Address pins
  logic beat_vld_o, beat_wr_o, dll_en_o, wb_ack_o; // Device outputs
  logic [13:0] beat_col_o;
  logic [1:0] drv_strength_o;
  logic [31:0] wb_dat_o;
  int failures, checks_done, beats_seen; // Counters

  //==========================================================================
  // Device, controller model and clock
  mrd_top #(.ADDR_W(14)) dut (.clk_i(clk_i), .rst_i(rst_i), .cmd_i(cmd), .addr_i(addr),
    .bank_i(bank), .beat_vld_o(beat_vld_o), .beat_wr_o(beat_wr_o), .beat_col_o(beat_col_o),
    .dll_en_o(dll_en_o), .drv_strength_o(drv_strength_o), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf),
    .wb_dat_i(wb_dat), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o));
  mrd_ctrl_model ctl (.clk_i(clk_i), .cmd_o(cmd), .addr_o(addr), .bank_o(bank));

  // 200 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // Counts every burst beat seen
  always @(posedge clk_i) begin
    if (beat_vld_o === 1'b1) beats_seen++;
  end

  //==========================================================================
  // Shared tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // One classic bus cycle, held until ack
  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] wd,
      output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_dat <= wd;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    if (n == 20) failures++;
    rd = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask : wb

  task automatic rd_chk(input logic [3:0] adr, input logic [31:0] exp);
    logic [31:0] d;
    wb(1'b0, adr, 32'h0, d);
    check(d, exp);
  endtask : rd_chk

  // Register set takes effect a few cycles after the pins
  task automatic settle();
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
  endtask : settle

  // Runs one burst and compares latency, order and direction
  task automatic burst(input logic wr, input logic len4, input logic ilv, input logic [13:0] a);
    int n;
    logic [1:0] m, lo;
    m = len4 ? 2'h3 : 2'h1;
    ctl.pair(wr ? CMD_WRITE_START : CMD_READ_START, CMD_LOWER_ADDR_LATCH, a, 3'h0);
    n = 1;
    @(negedge clk_i);
    while (beat_vld_o !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
      @(negedge clk_i);
    end
    check(32'(n), wr ? 32'h5 : 32'h6);
    for (int k = 0; k < (len4 ? 4 : 2); k++) begin
      lo = ilv ? (a[1:0] ^ (k[1:0] & m)) : ((a[1:0] & ~m) | ((a[1:0] + k[1:0]) & m));
      check(32'(beat_col_o), 32'({a[13:2], lo}));
      check(32'(beat_wr_o), 32'(wr));
      @(negedge clk_i);
    end
    check(32'(beat_vld_o), 32'h0);
  endtask : burst

  //==========================================================================
  // Scenarios
  task automatic t_reset();
    rd_chk(OFS_CTRL, 32'h1);
    rd_chk(OFS_STATUS, 32'h0);
    rd_chk(OFS_REGULAR, 32'h0);
    rd_chk(4'h2, 32'h0);
    check(32'(dll_en_o), 32'h1);
    check(32'(drv_strength_o), 32'h0);
    $display("test reset done");
  endtask : t_reset

  // Every drive pattern through the extended register
  task automatic t_ext();
    int b0;
    logic [1:0] d;
    b0 = beats_seen;
    for (int i = 0; i < 4; i++) begin
      d = i[1:0];
      ctl.reg_set(3'h1, {7'h0, d[1], 4'h0, d[0], 1'b0});
      settle();
      check(32'(drv_strength_o), 32'(d));
      check(32'(dll_en_o), 32'h1);
      rd_chk(OFS_EXTENDED, {25'h0, d[1], 4'h0, d[0], 1'b0});
    end
    check(32'(beats_seen - b0), 32'h0);
    rd_chk(OFS_STATUS, 32'h2);
    $display("test extended done");
  endtask : t_ext

  // Each length and order, read then write, awkward start addresses
  task automatic t_burst();
    logic [3:0] tbl [4] = '{4'b1011, 4'b1110, 4'b0001, 4'b0100};
    logic [2:0] len;
    for (int i = 0; i < 4; i++) begin
      len = tbl[i][3] ? LEN_4 : LEN_2;
      ctl.reg_set(3'h0, {7'h0, CL_4, tbl[i][2], len});
      settle();
      rd_chk(OFS_REGULAR, {24'h0, 1'b0, CL_4, tbl[i][2], len});
      burst(1'b0, tbl[i][3], tbl[i][2], {12'h2a5, tbl[i][1:0]});
      burst(1'b1, tbl[i][3], tbl[i][2], {12'h15a, tbl[i][1:0]});
    end
    $display("test bursts done");
  endtask : t_burst

  // Refused register sets leave the settings alone
  task automatic t_refuse();
    logic [31:0] d;
    ctl.pair(CMD_WRITE_START, CMD_REG_SET, 14'h0000, 3'h1);
    settle();
    check(32'(drv_strength_o), 32'h3);
    ctl.reg_set(3'h2, 14'h0000);
    settle();
    check(32'(drv_strength_o), 32'h3);
    rd_chk(OFS_STATUS, 32'h7);
    wb(1'b1, OFS_STATUS, 32'h4, d);
    rd_chk(OFS_STATUS, 32'h3);
    wb(1'b1, OFS_CTRL, 32'h0, d);
    ctl.reg_set(3'h1, 14'h0000);
    settle();
    check(32'(drv_strength_o), 32'h3);
    wb(1'b1, OFS_CTRL, 32'h1, d);
    // Reserved latency code is stored but flagged
    ctl.pair(CMD_READ_START, CMD_REG_SET, 14'h0031, 3'h0);
    settle();
    rd_chk(OFS_STATUS, 32'hb);
    rd_chk(OFS_REGULAR, 32'h31);
    // Loop-off bit turns the loop off, drive back to normal
    ctl.pair(CMD_READ_START, CMD_REG_SET, 14'h0001, 3'h1);
    settle();
    check(32'(dll_en_o), 32'h0);
    check(32'(drv_strength_o), 32'h0);
    wb(1'b1, OFS_STATUS, 32'h8, d);
    rd_chk(OFS_STATUS, 32'h3);
    $display("test refused done");
  endtask : t_refuse

  //==========================================================================
  // Verdict and run control
  task automatic end_of_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test

  // Watchdog well beyond the expected few hundred cycles
  initial begin
    #50000;
    failures++;
    end_of_test();
  end

  // Main sequence
  initial begin
    failures = 0;
    checks_done = 0;
    beats_seen = 0;
    {wb_cyc, wb_stb, wb_we} = 3'h0;
    wb_adr = 4'h0;
    wb_dat = 32'h0;
    rst_i = 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_ext();
    t_burst();
    t_refuse();
    end_of_test();
  end
endmodule : mrd_top_tb
